// *** inc/mdf_pkg.sv ***
// Constants, register layout and carrier types of the motor driver fault supervisor.
package mdf_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_NS = 20;
    localparam int CNT_W = 18;
    localparam int DEG_W = 6;
    localparam int NUM_FET = 6;
    // Fixed overcurrent deglitch, and the longer selectable one.
    localparam int OVERCURRENT_DEGLITCH_SEL_HW_NS = 600;
    localparam int OVERCURRENT_DEGLITCH_SEL_LONG_NS = 1200;
    localparam logic [DEG_W-1:0] DEG_HW_CYC =
        DEG_W'((OVERCURRENT_DEGLITCH_SEL_HW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [DEG_W-1:0] DEG_LONG_CYC =
        DEG_W'((OVERCURRENT_DEGLITCH_SEL_LONG_NS + CLK_NS - 1) / CLK_NS);
    // Longest low time of a clear-faults pulse on the sleep pin.
    localparam int RST_WIN_NS = 10000;
    localparam logic [CNT_W-1:0] RST_WIN_CYC = CNT_W'(RST_WIN_NS / CLK_NS);

    // ==========================================================
    // Register map
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_CTRL = 8'h04;
    localparam logic [7:0] ADR_LIVE = 8'h08;
    localparam int CLR_BIT = 0;

    // Overcurrent response codes.
    localparam logic [1:0] OCP_LATCH = 2'h0;
    localparam logic [1:0] OCP_RETRY = 2'h1;
    localparam logic [1:0] OCP_REPORT = 2'h2;
    localparam logic [1:0] OCP_OFF = 2'h3;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {MDF_SLEEP, MDF_WAKE, MDF_RUN, MDF_ENTER} mdf_pwr_type;

    typedef struct packed {
        logic buck_undervolt_flag;
        logic pump_low;
        logic ov22;
        logic ov34;
        logic buck_oc;
        logic overtemp_warn_flag;
        logic tsd_fet;
        logic tsd;
        logic sleep_n;
        logic vm_ok;
        logic overcurrent_level_sel_pin;
        logic serial_var;
        logic [NUM_FET-1:0] fet_oc;
    } mdf_cond_type;

    typedef struct packed {
        logic overcurrent_deglitch_sel;
        logic overcurrent_level_sel;
        logic [1:0] overcurrent_mode_sel;
        logic overtemp_warn_report;
        logic ovp_lvl;
        logic overvolt_enable;
        logic spare;
    } mdf_ctrl_type;

    typedef struct packed {
        logic [NUM_FET-1:0] fet_ocp;
        logic thermal_shutdown_flag;
        logic ot_sum;
        logic overtemp_warn_flag;
        logic overcurrent_flag;
        logic ov;
        logic pump_uv;
        logic buck_oc;
        logic buck_undervolt_flag;
        logic buck_flt;
        logic fault;
    } mdf_flags_type;

    typedef struct packed {
        logic fault_n;
        logic fet_en;
        logic csa_en;
        logic buck_en;
        logic pump_en;
        logic analog_en;
        logic serial_en;
        logic overcurrent_level_sel;
    } mdf_drive_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } mdf_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } mdf_wb_rsp_type;

    typedef struct packed {
        mdf_cond_type s1;
        mdf_cond_type s2;
        logic serial;
        mdf_ctrl_type ctrl;
        mdf_flags_type flags;
        mdf_drive_type drv;
        mdf_wb_rsp_type rsp;
        mdf_pwr_type pwr;
        logic [CNT_W-1:0] pwr_cnt;
        logic [CNT_W-1:0] retry_cnt;
        logic [CNT_W-1:0] bk_cnt;
        logic [NUM_FET-1:0][DEG_W-1:0] deg_cnt;
        logic ocp_hold;
        logic clr;
    } mdf_state_type;

    localparam mdf_ctrl_type CTRL_RST = '0;
    localparam mdf_drive_type DRV_RST = 8'h80;

endpackage

// *** rtl/mdf_supervisor.sv ***
// Fault supervision and power-mode control of a three-phase motor driver.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps

module mdf_supervisor #(
    parameter int RETRY_US = 5000,
    parameter int SLEEP_US = 120,
    parameter int WAKE_US = 1000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire mdf_pkg::mdf_cond_type cond,
    input wire mdf_pkg::mdf_wb_req_type wb_req,
    output mdf_pkg::mdf_wb_rsp_type wb_rsp,
    output mdf_pkg::mdf_drive_type drv
);

    // ==========================================================
    // Derived cycle counts
    localparam logic [mdf_pkg::CNT_W-1:0] RETRY_CYC =
        mdf_pkg::CNT_W'((RETRY_US * 1000 + mdf_pkg::CLK_NS - 1) / mdf_pkg::CLK_NS);
    localparam logic [mdf_pkg::CNT_W-1:0] SLEEP_CYC =
        mdf_pkg::CNT_W'((SLEEP_US * 1000 + mdf_pkg::CLK_NS - 1) / mdf_pkg::CLK_NS);
    localparam logic [mdf_pkg::CNT_W-1:0] WAKE_CYC =
        mdf_pkg::CNT_W'((WAKE_US * 1000 + mdf_pkg::CLK_NS - 1) / mdf_pkg::CLK_NS);

    mdf_pkg::mdf_state_type st_q;
    mdf_pkg::mdf_state_type st_d;
    logic [1:0] eff_mode;
    logic [mdf_pkg::DEG_W-1:0] deg_lim;
    logic ov_cond;
    logic regs_on;
    logic active;
    logic moving;
    logic [mdf_pkg::NUM_FET-1:0] fet_ev;
    logic ocp_ev;
    logic bk_ev;
    logic rst_pulse;
    logic bus_wr;
    logic clr_wr;
    logic any_fault;
    logic deg_idle;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Effective configuration; the pin variant ignores the serial mode, deglitch, overvoltage and level settings.
    assign eff_mode = st_q.serial ? st_q.ctrl.overcurrent_mode_sel : mdf_pkg::OCP_LATCH;
    assign deg_lim = (st_q.serial && st_q.ctrl.overcurrent_deglitch_sel) ? mdf_pkg::DEG_LONG_CYC
                                                         : mdf_pkg::DEG_HW_CYC;
    assign ov_cond = st_q.serial
        ? (st_q.ctrl.overvolt_enable && (st_q.ctrl.ovp_lvl ? st_q.s2.ov22 : st_q.s2.ov34))
        : st_q.s2.ov34;

    // Regulators run outside sleep; FETs only once the wake delay has passed.
    assign regs_on = (st_q.pwr != mdf_pkg::MDF_SLEEP);
    assign active = (st_q.pwr == mdf_pkg::MDF_RUN) || (st_q.pwr == mdf_pkg::MDF_ENTER);
    // Regulators are changing state: waking, or past the reset-pulse window.
    assign moving = (st_q.pwr == mdf_pkg::MDF_WAKE)
        || (st_q.pwr == mdf_pkg::MDF_ENTER && st_q.pwr_cnt >= mdf_pkg::RST_WIN_CYC);

    // Overcurrent is an event only when a counter first reaches the deglitch limit.
    always_comb begin
        for (int i = 0; i < mdf_pkg::NUM_FET; i++) begin
            fet_ev[i] = st_q.s2.fet_oc[i] && (eff_mode != mdf_pkg::OCP_OFF)
                && (st_q.deg_cnt[i] == deg_lim - 6'h01);
        end
    end
    assign ocp_ev = |fet_ev;
    assign deg_idle = (st_q.deg_cnt == '0);
    assign bk_ev = st_q.s2.buck_oc && (st_q.bk_cnt == '0) && regs_on;

    // A high level back on the pin within the window is a clear, not a sleep.
    assign rst_pulse = (st_q.pwr == mdf_pkg::MDF_ENTER) && st_q.s2.sleep_n
        && (st_q.pwr_cnt < mdf_pkg::RST_WIN_CYC);

    // A write takes effect at the edge where the master sees the ack.
    assign bus_wr = wb_req.cyc && wb_req.stb && wb_req.we && st_q.rsp.ack
        && (wb_req.adr == mdf_pkg::ADR_CTRL) && wb_req.sel[0];
    assign clr_wr = bus_wr && wb_req.dat[mdf_pkg::CLR_BIT];

    // Every source that is still asking for the fault pin.
    assign any_fault = regs_on && (st_q.s2.buck_undervolt_flag || st_q.s2.pump_low || ov_cond
        || (st_q.ocp_hold && eff_mode != mdf_pkg::OCP_OFF)
        || (st_q.retry_cnt != '0) || (st_q.bk_cnt != '0)
        || (st_q.s2.overtemp_warn_flag && st_q.ctrl.overtemp_warn_report)
        || st_q.s2.tsd_fet || st_q.s2.tsd);

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        // Two-stage synchroniser on every comparator and pin.
        st_d.s1 = cond;
        st_d.s2 = st_q.s1;
        st_d.clr = clr_wr || rst_pulse;

        // Straps are sampled while asleep, so they are settled before use.
        if (st_q.pwr == mdf_pkg::MDF_SLEEP) begin
            st_d.serial = st_q.s2.serial_var;
        end

        // Power sequencing.
        unique case (st_q.pwr)
            mdf_pkg::MDF_SLEEP: begin
                st_d.pwr_cnt = '0;
                if (st_q.s2.sleep_n && st_q.s2.vm_ok) begin
                    st_d.pwr = mdf_pkg::MDF_WAKE;
                end
            end
            mdf_pkg::MDF_WAKE: begin
                st_d.pwr_cnt = st_q.pwr_cnt + 18'h00001;
                if (!st_q.s2.sleep_n || !st_q.s2.vm_ok) begin
                    st_d.pwr = mdf_pkg::MDF_SLEEP;
                end else if (st_q.pwr_cnt >= WAKE_CYC - 18'h00001) begin
                    st_d.pwr = mdf_pkg::MDF_RUN;
                end
            end
            mdf_pkg::MDF_RUN: begin
                st_d.pwr_cnt = '0;
                if (!st_q.s2.vm_ok) begin
                    st_d.pwr = mdf_pkg::MDF_SLEEP;
                end else if (!st_q.s2.sleep_n) begin
                    st_d.pwr = mdf_pkg::MDF_ENTER;
                end
            end
            mdf_pkg::MDF_ENTER: begin
                st_d.pwr_cnt = st_q.pwr_cnt + 18'h00001;
                if (rst_pulse) begin
                    st_d.pwr = mdf_pkg::MDF_RUN;
                end else if (st_q.pwr_cnt >= SLEEP_CYC - 18'h00001 || !st_q.s2.vm_ok) begin
                    st_d.pwr = mdf_pkg::MDF_SLEEP;
                end
            end
        endcase

        // Control register; the serial port forgets its settings in sleep.
        if (st_q.pwr == mdf_pkg::MDF_SLEEP) begin
            st_d.ctrl = mdf_pkg::CTRL_RST;
        end else if (bus_wr) begin
            st_d.ctrl = mdf_pkg::mdf_ctrl_type'(wb_req.dat[7:0]);
            st_d.ctrl.spare = 1'b0;
        end

        // Deglitch counters saturate at the limit, so one event per episode.
        for (int i = 0; i < mdf_pkg::NUM_FET; i++) begin
            if (st_q.s2.fet_oc[i] && eff_mode != mdf_pkg::OCP_OFF && active) begin
                if (st_q.deg_cnt[i] < deg_lim) begin
                    st_d.deg_cnt[i] = st_q.deg_cnt[i] + 6'h01;
                end
            end else begin
                st_d.deg_cnt[i] = '0;
            end
        end

        // Latched and report modes hold until cool and cleared.
        if (ocp_ev && (eff_mode == mdf_pkg::OCP_LATCH || eff_mode == mdf_pkg::OCP_REPORT)) begin
            st_d.ocp_hold = 1'b1;
        end else if (st_q.clr && st_q.s2.fet_oc == '0) begin
            st_d.ocp_hold = 1'b0;
        end

        // Retry timers recover by themselves.
        if (ocp_ev && eff_mode == mdf_pkg::OCP_RETRY) begin
            st_d.retry_cnt = RETRY_CYC;
        end else if (st_q.retry_cnt != '0) begin
            st_d.retry_cnt = st_q.retry_cnt - 18'h00001;
        end
        if (bk_ev) begin
            st_d.bk_cnt = RETRY_CYC;
        end else if (st_q.bk_cnt != '0) begin
            st_d.bk_cnt = st_q.bk_cnt - 18'h00001;
        end

        // Sticky flags: a new event always wins over a clear in the same cycle.
        if (st_q.clr) begin
            st_d.flags.fault = 1'b0;
            st_d.flags.buck_undervolt_flag = 1'b0;
            st_d.flags.buck_flt = 1'b0;
            st_d.flags.pump_uv = 1'b0;
            st_d.flags.ov = 1'b0;
            st_d.flags.overcurrent_flag = 1'b0;
            st_d.flags.fet_ocp = '0;
            st_d.flags.ot_sum = 1'b0;
            st_d.flags.thermal_shutdown_flag = 1'b0;
            st_d.flags.overtemp_warn_flag = st_q.s2.overtemp_warn_flag && st_q.flags.overtemp_warn_flag;
        end
        if (st_q.bk_cnt == 18'h00001) begin
            st_d.flags.buck_oc = 1'b0;
            st_d.flags.buck_flt = 1'b0;
        end
        if (regs_on && st_q.s2.buck_undervolt_flag) begin
            st_d.flags.buck_undervolt_flag = 1'b1;
            st_d.flags.buck_flt = 1'b1;
            st_d.flags.fault = 1'b1;
        end
        if (bk_ev) begin
            st_d.flags.buck_oc = 1'b1;
            st_d.flags.buck_flt = 1'b1;
            st_d.flags.fault = 1'b1;
        end
        if (regs_on && st_q.s2.pump_low) begin
            st_d.flags.pump_uv = 1'b1;
            st_d.flags.fault = 1'b1;
        end
        if (regs_on && ov_cond) begin
            st_d.flags.ov = 1'b1;
            st_d.flags.fault = 1'b1;
        end
        if (ocp_ev) begin
            st_d.flags.overcurrent_flag = 1'b1;
            st_d.flags.fet_ocp = st_q.flags.fet_ocp | fet_ev;
            st_d.flags.fault = 1'b1;
        end
        if (regs_on && st_q.s2.overtemp_warn_flag) begin
            st_d.flags.overtemp_warn_flag = 1'b1;
            st_d.flags.ot_sum = 1'b1;
        end
        if (regs_on && (st_q.s2.tsd_fet || st_q.s2.tsd)) begin
            st_d.flags.thermal_shutdown_flag = 1'b1;
            st_d.flags.ot_sum = 1'b1;
            st_d.flags.fault = 1'b1;
        end

        // Power gating; the buck is the only thing a buck fault stops.
        st_d.drv.fet_en = active && !st_q.s2.pump_low && !ov_cond && !st_q.s2.tsd_fet
            && !st_q.s2.tsd && (st_q.retry_cnt == '0)
            && !(st_q.ocp_hold && eff_mode == mdf_pkg::OCP_LATCH);
        st_d.drv.buck_en = regs_on && !st_q.s2.buck_undervolt_flag && (st_q.bk_cnt == '0)
            && !st_q.s2.tsd;
        st_d.drv.pump_en = regs_on && !st_q.s2.tsd_fet && !st_q.s2.tsd;
        st_d.drv.analog_en = regs_on;
        st_d.drv.serial_en = regs_on;
        st_d.drv.csa_en = active;
        st_d.drv.overcurrent_level_sel = st_q.serial ? st_q.ctrl.overcurrent_level_sel : st_q.s2.overcurrent_level_sel_pin;
        st_d.drv.fault_n = !(any_fault || moving);

        // Wishbone slave: one wait state, then a single-cycle ack.
        st_d.rsp.ack = wb_req.cyc && wb_req.stb && !st_q.rsp.ack;
        st_d.rsp.dat = '0;
        if (st_d.rsp.ack) begin
            unique case (wb_req.adr)
                mdf_pkg::ADR_STATUS: st_d.rsp.dat = {16'h0000, st_q.flags};
                mdf_pkg::ADR_CTRL: st_d.rsp.dat = {24'h000000, st_q.ctrl};
                mdf_pkg::ADR_LIVE: st_d.rsp.dat = {21'h000000, st_q.serial, st_q.pwr, st_q.drv};
                default: st_d.rsp.dat = '0;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.pwr <= mdf_pkg::MDF_SLEEP;
            st_q.ctrl <= mdf_pkg::CTRL_RST;
            st_q.drv <= mdf_pkg::DRV_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_rsp = st_q.rsp;
    assign drv = st_q.drv;

    // ==========================================================
    // Assertions
    a_buck_undervolt_flag_resp: assert property (
        st_q.pwr == mdf_pkg::MDF_RUN && st_q.s2.buck_undervolt_flag
        |=> !drv.fault_n && !drv.buck_en && st_q.flags.buck_undervolt_flag && st_q.flags.buck_flt)
        else $error("buck undervoltage not handled");
    a_buck_flag_keep: assert property (
        st_q.flags.buck_undervolt_flag && !st_q.clr |=> st_q.flags.buck_undervolt_flag)
        else $error("buck undervoltage flag lost");
    a_pump_uv_off: assert property (
        active && st_q.s2.pump_low |=> !drv.fet_en && !drv.fault_n && st_q.flags.pump_uv)
        else $error("pump undervoltage not handled");
    a_ov_fets_off: assert property (
        regs_on && ov_cond |=> !drv.fet_en && !drv.fault_n && st_q.flags.ov)
        else $error("overvoltage not handled");
    a_ov_disabled: assert property (
        st_q.serial && !st_q.ctrl.overvolt_enable && !st_q.flags.ov |=> !st_q.flags.ov)
        else $error("overvoltage acted while disabled");
    a_ocp_deglitch: assert property (
        deg_idle && !st_q.flags.overcurrent_flag |=> !st_q.flags.overcurrent_flag)
        else $error("overcurrent taken before deglitch");
    a_ocp_latch_off: assert property (
        st_q.ocp_hold && eff_mode == mdf_pkg::OCP_LATCH |=> !drv.fet_en)
        else $error("latched overcurrent drove FETs");
    a_ocp_retry_hold: assert property (
        st_q.retry_cnt > 18'h00002 |=> !drv.fet_en ##1 !drv.fet_en)
        else $error("FETs on during retry");
    a_ocp_off_mode: assert property (
        eff_mode == mdf_pkg::OCP_OFF && !st_q.flags.overcurrent_flag |=> !st_q.flags.overcurrent_flag)
        else $error("disabled overcurrent set a flag");
    a_otw_hold: assert property (
        st_q.flags.overtemp_warn_flag && st_q.s2.overtemp_warn_flag |=> st_q.flags.overtemp_warn_flag)
        else $error("warning flag cleared while hot");
    a_tsd_all_off: assert property (
        regs_on && st_q.s2.tsd |=> !drv.fet_en && !drv.buck_en && !drv.pump_en && !drv.fault_n)
        else $error("die shutdown not handled");
    a_sleep_off: assert property (
        st_q.pwr == mdf_pkg::MDF_SLEEP |=> !drv.fet_en && !drv.analog_en && !drv.serial_en)
        else $error("blocks on in sleep");
    a_wb_ack_once: assert property (
        wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack held two cycles");
    a_pump_uv_any: assert property (
        regs_on && st_q.s2.pump_low |=> st_q.flags.pump_uv && !drv.fault_n)
        else $error("pump undervoltage ignored");
    a_ocp_report_run: assert property (
        active && eff_mode == mdf_pkg::OCP_REPORT && st_q.retry_cnt == '0 && !ov_cond
        && !st_q.s2.pump_low && !st_q.s2.tsd_fet && !st_q.s2.tsd |=> drv.fet_en)
        else $error("report mode stopped the FETs");
    a_boc_start: assert property (
        bk_ev |=> st_q.flags.buck_oc ##1 !drv.buck_en)
        else $error("buck overcurrent not handled");
    a_boc_expire: assert property (
        st_q.bk_cnt == 18'h00001 |=> !st_q.flags.buck_oc)
        else $error("buck overcurrent flag kept");
    a_otw_flags: assert property (
        regs_on && st_q.s2.overtemp_warn_flag |=> st_q.flags.overtemp_warn_flag && st_q.flags.ot_sum)
        else $error("warning flags not set");
    a_fet_tsd_off: assert property (
        regs_on && st_q.s2.tsd_fet
        |=> !drv.fet_en && !drv.pump_en && !drv.fault_n && st_q.flags.thermal_shutdown_flag)
        else $error("FET shutdown not handled");

    // Sleep pin sequencing and the fault pin during regulator changes.
    a_sleep_wake: assert property (
        st_q.pwr == mdf_pkg::MDF_SLEEP && st_q.s2.sleep_n && st_q.s2.vm_ok
        |=> st_q.pwr == mdf_pkg::MDF_WAKE)
        else $error("no wake on sleep pin high");
    a_wake_fault: assert property (
        st_q.pwr == mdf_pkg::MDF_WAKE |=> !drv.fault_n)
        else $error("fault released during wake");
    a_run_regs_on: assert property (
        st_q.pwr == mdf_pkg::MDF_RUN |=> drv.analog_en && drv.serial_en && drv.csa_en)
        else $error("regulators off while running");
    a_reset_pulse: assert property (
        rst_pulse |=> st_q.clr && st_q.pwr == mdf_pkg::MDF_RUN)
        else $error("reset pulse not taken as clear");
    a_fault_or: assert property (
        any_fault |=> !drv.fault_n)
        else $error("fault source not reported");

    c_ocp_event: cover property (ocp_ev);
    c_retry_done: cover property (st_q.retry_cnt == 18'h00001);
    c_reset_pulse: cover property (rst_pulse);
    c_enter_sleep: cover property (st_q.pwr == mdf_pkg::MDF_ENTER ##1 st_q.pwr == mdf_pkg::MDF_SLEEP);
    c_wake_done: cover property (st_q.pwr == mdf_pkg::MDF_WAKE ##1 st_q.pwr == mdf_pkg::MDF_RUN);

endmodule

// *** sim/mdf_host_model.sv ***
// Behavioural external controller that drives the sleep pin and waits out wake-up.
`timescale 1ns/100ps
module mdf_host_model #(
    parameter int WAKE_CYC = 100
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sleep_req,
    output logic sleep_n,
    output logic ready
);
    // ==========================================================
    // Sleep pin and wake wait
    logic [15:0] wait_q;

    // Traffic is held off for the wake delay plus sync slack, though the block drops control writes only while asleep.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sleep_n <= 1'b0;
            wait_q <= 16'h0;
        end else begin
            sleep_n <= !sleep_req;
            if (!sleep_n) begin
                wait_q <= 16'h0;
            end else if (wait_q < 16'(WAKE_CYC + 8)) begin
                wait_q <= wait_q + 16'h1;
            end
        end
    end

    // Ready only once the full wait has run out.
    assign ready = sleep_n && (wait_q == 16'(WAKE_CYC + 8));
endmodule

// *** sim/tb.sv ***
// Self-checking testbench of the motor driver fault supervisor.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
    // ==========================================================
    // Signals and instances
    logic ref_clk;
    logic rst;
    logic sleep_req;
    logic sleep_n;
    logic ready;
    mdf_pkg::mdf_cond_type c;
    mdf_pkg::mdf_cond_type cond_w;
    mdf_pkg::mdf_wb_req_type wb_req;
    mdf_pkg::mdf_wb_rsp_type wb_rsp;
    mdf_pkg::mdf_drive_type drv;
    int num_errors = 0;
    int checked = 0;

    // The sleep pin comes from the controller model, the rest from the bench.
    always_comb begin
        cond_w = c;
        cond_w.sleep_n = sleep_n;
    end

    mdf_supervisor #(.RETRY_US(5), .SLEEP_US(20), .WAKE_US(2)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .cond(cond_w), .wb_req(wb_req), .wb_rsp(wb_rsp), .drv(drv));
    mdf_host_model #(.WAKE_CYC(100)) host_u (
        .ref_clk(ref_clk), .rst(rst), .sleep_req(sleep_req), .sleep_n(sleep_n), .ready(ready));

    // Free-running 50 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Common tasks
    task end_sim;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One classic cycle; the request holds until ack is sampled, only the watchdog ends a hang.
    task wb_rw(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        do begin
            @(posedge ref_clk);
        end while (wb_rsp.ack !== 1'b1);
        q = wb_rsp.dat;
        wb_req <= '0;
    endtask

    // Fault output, FET, buck and pump enables, in that order.
    function automatic logic [3:0] dv();
        return {drv.fault_n, drv.fet_en, drv.buck_en, drv.pump_en};
    endfunction

    // A short low pulse on the sleep pin; the buck must keep running through it.
    task pulse_clr;
        sleep_req <= 1'b1;
        repeat (100) @(posedge ref_clk);
        `CHK(drv.buck_en, 1'b1)
        sleep_req <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask

    // ==========================================================
    // Scenarios
    task t_wake;
        int n;
        sleep_req <= 1'b0;
        repeat (10) @(posedge ref_clk);
        `CHK(drv.fault_n, 1'b0)
        n = 0;
        while (ready !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(drv[7:1], 7'h7f)
        $display("test wake done");
    endtask

    task t_regs;
        logic [31:0] q;
        wb_rw(1'b1, mdf_pkg::ADR_CTRL, 32'h000000ff, q);
        wb_rw(1'b0, mdf_pkg::ADR_CTRL, 32'h0, q);
        `CHK(q, 32'h000000fe)
        wb_rw(1'b0, mdf_pkg::ADR_LIVE, 32'h0, q);
        `CHK(q, 32'h000006ff)
        wb_rw(1'b1, mdf_pkg::ADR_STATUS, 32'h0000ffff, q);
        wb_rw(1'b0, mdf_pkg::ADR_STATUS, 32'h0, q);
        `CHK(q, 32'h0)
        wb_rw(1'b0, 8'h0c, 32'h0, q);
        `CHK(q, 32'h0)
        $display("test registers done");
    endtask

    // Raise a condition, check the reaction and recovery, the latched flags, then clear by pulse.
    task t_fault(input logic [17:0] m, input logic [7:0] ctl, input logic [3:0] e,
                 input logic [15:0] es, input logic [15:0] mk);
        logic [31:0] q;
        wb_rw(1'b1, mdf_pkg::ADR_CTRL, {24'h0, ctl}, q);
        c <= c | m;
        repeat (5) @(posedge ref_clk);
        `CHK(dv(), e)
        c <= c & ~m;
        repeat (5) @(posedge ref_clk);
        `CHK(dv(), 4'hf)
        wb_rw(1'b0, mdf_pkg::ADR_STATUS, 32'h0, q);
        `CHK(q[15:0] & mk, es)
        pulse_clr;
        wb_rw(1'b0, mdf_pkg::ADR_STATUS, 32'h0, q);
        `CHK(q[15:0], 16'h0)
        $display("test condition %0h done", m);
    endtask

    task t_boc;
        logic [31:0] q;
        c.buck_oc <= 1'b1;
        repeat (10) @(posedge ref_clk);
        c.buck_oc <= 1'b0;
        `CHK(dv(), 4'h5)
        wb_rw(1'b0, mdf_pkg::ADR_STATUS, 32'h0, q);
        `CHK(q[3:0], 4'hb)
        repeat (260) @(posedge ref_clk);
        `CHK(dv(), 4'hf)
        wb_rw(1'b0, mdf_pkg::ADR_STATUS, 32'h0, q);
        `CHK(q[3:1], 3'h0)
        pulse_clr;
        $display("test buck overcurrent done");
    endtask

    // Every response mode in turn, each finished by the clear bit.
    task t_ocp;
        logic [31:0] q;
        for (int md = 0; md < 4; md++) begin
            wb_rw(1'b1, mdf_pkg::ADR_CTRL, 32'(md * 16), q);
            c.fet_oc <= 6'h01;
            repeat (20) @(posedge ref_clk);
            `CHK({drv.fault_n, drv.fet_en}, 2'b11)
            repeat (20) @(posedge ref_clk);
            `CHK({drv.fault_n, drv.fet_en}, {md == 3, md > 1})
            c.fet_oc <= 6'h00;
            repeat (5) @(posedge ref_clk);
            if (md == 1) repeat (260) @(posedge ref_clk);
            `CHK({drv.fault_n, drv.fet_en}, {md == 1 || md == 3, md != 0})
            wb_rw(1'b0, mdf_pkg::ADR_STATUS, 32'h0, q);
            `CHK(q[15:0], (md == 3) ? 16'h0 : 16'h0441)
            wb_rw(1'b1, mdf_pkg::ADR_CTRL, 32'(md * 16 + 1), q);
            repeat (3) @(posedge ref_clk);
            `CHK({drv.fault_n, drv.fet_en}, 2'b11)
        end
        $display("test overcurrent modes done");
    endtask

    task t_deg;
        logic [31:0] q;
        wb_rw(1'b1, mdf_pkg::ADR_CTRL, 32'h000000c0, q);
        repeat (3) @(posedge ref_clk);
        `CHK(drv.overcurrent_level_sel, 1'b1)
        c.fet_oc <= 6'h01;
        repeat (45) @(posedge ref_clk);
        `CHK(drv.fault_n, 1'b1)
        repeat (30) @(posedge ref_clk);
        `CHK(drv.fault_n, 1'b0)
        c.fet_oc <= 6'h00;
        wb_rw(1'b1, mdf_pkg::ADR_CTRL, 32'h000000c1, q);
        repeat (3) @(posedge ref_clk);
        `CHK(drv.fault_n, 1'b1)
        $display("test long deglitch done");
    endtask

    task t_sleep;
        int n;
        sleep_req <= 1'b1;
        repeat (400) @(posedge ref_clk);
        `CHK({drv.fault_n, drv.fet_en}, 2'b11)
        repeat (200) @(posedge ref_clk);
        `CHK(drv.fault_n, 1'b0)
        n = 600;
        while (drv.fet_en !== 1'b0 && n < 1200) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(n > 990 && n < 1010, 1'b1)
        `CHK(drv[6:1], 6'h00)
        `CHK(drv.fault_n, 1'b1)
        $display("test sleep done");
    endtask

    // ==========================================================
    // Main sequence: serial variant first, then the pin variant after a full sleep.
    initial begin
        rst = 1'b1;
        c = 18'h00140;
        wb_req = '0;
        sleep_req = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_wake;
        t_regs;
        t_fault(18'h20000, 8'h00, 4'h5, 16'h0007, 16'hffff);
        t_fault(18'h10000, 8'h00, 4'h3, 16'h0011, 16'hffff);
        t_fault(18'h08000, 8'h06, 4'h3, 16'h0021, 16'hffff);
        t_fault(18'h0c000, 8'h00, 4'hf, 16'h0000, 16'hffff);
        t_fault(18'h08000, 8'h02, 4'hf, 16'h0000, 16'hffff);
        t_fault(18'h04000, 8'h02, 4'h3, 16'h0021, 16'hffff);
        t_fault(18'h01000, 8'h00, 4'hf, 16'h0180, 16'hffff);
        t_fault(18'h01000, 8'h08, 4'h7, 16'h0180, 16'hfffe);
        t_fault(18'h00800, 8'h00, 4'h2, 16'h0301, 16'hffff);
        t_fault(18'h00400, 8'h00, 4'h0, 16'h0301, 16'hffff);
        t_boc;
        t_ocp;
        t_deg;
        t_sleep;
        c.serial_var <= 1'b0;
        c.overcurrent_level_sel_pin <= 1'b1;
        t_wake;
        `CHK(drv.overcurrent_level_sel, 1'b1)
        t_fault(18'h0c000, 8'h00, 4'h3, 16'h0021, 16'hffff);
        end_sim;
    end

    // A run of about four thousand cycles is expected; five times that means a hang.
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        end_sim;
    end
endmodule
